// *** src/csf_flag_words.sv ***
// System flag words with a classic Wishbone register slave
`timescale 1ns/1ps
// Contract
// - Log clear bit erases log, self-clears after
// - Detected error writes code to bits 7:0
// - Alarm instructions load their number into code
// - Alarm zero or peripheral clear zeroes code
// - Scan longer than 100 ms sets bit 9
// - First-scan flag high exactly one scan
// - Timing bit 0: 30 s on, 30 s off
// - Timing bit 1: 10 ms on, 10 ms off
// - Timing bit 6 set when differential monitor done
// - Timing bit 7 high one scan per step
module csf_flag_words #(
    parameter int unsigned OVERRUN_CYCLES = csf_pkg::OVERRUN_CYC,
    parameter int unsigned FAST_HALF      = csf_pkg::FAST_HALF_CYC,
    parameter int unsigned SLOW_HALF      = csf_pkg::SLOW_HALF_CYC
) (
    // Clock, reset, enable
    input  wire logic                   clk_i,
    input  wire logic                   rst_i,
    input  wire logic                   ce_i,
    // Wishbone slave
    input  wire logic                   wb_cyc_i,
    input  wire logic                   wb_stb_i,
    input  wire logic                   wb_we_i,
    input  wire logic [csf_pkg::ADDR_W-1:0] wb_adr_i,
    input  wire logic [3:0]             wb_sel_i,
    input  wire logic [31:0]            wb_dat_i,
    output logic      [31:0]            wb_dat_o,
    output logic                        wb_ack_o,
    // Scan engine events
    input  wire csf_pkg::csf_scan_type  scan_i,
    input  wire csf_pkg::csf_alarm_type alarm_i,
    input  wire csf_pkg::csf_error_type error_i,
    input  wire logic                   arith_valid_i,
    input  wire logic                   arith_neg_i,
    // Peripheral tool
    input  wire logic                   periph_err_clear_i,
    input  wire logic                   diff_mon_start_i,
    input  wire logic                   diff_mon_done_i,
    // Error log store
    input  wire logic                   log_erase_done_i,
    output logic                        log_erase_o,
    // Flag words for the user program
    output logic      [15:0]            err_word_o,
    output logic      [15:0]            tim_word_o,
    // Interrupt
    output logic                        irq_o
);
    import csf_pkg::*;

    // Bus decode
    logic              bus_req;
    logic              bus_wr;
    logic [7:0]        bus_idx;
    logic              adr_aligned;
    logic              next_ack;
    logic [31:0]       next_dat;

    // Flag state
    logic [7:0]        err_code;
    logic [7:0]        next_err_code;
    logic              overrun;
    logic              next_overrun;
    logic              first_scan;
    logic              next_first_scan;
    logic              step_flag;
    logic              next_step_flag;
    logic              diff_flag;
    logic              next_diff_flag;
    logic              neg_flag;
    logic              next_neg_flag;
    logic              log_clear;
    logic              next_log_clear;
    logic              running;
    logic              next_running;
    logic [15:0]       next_err_word;
    logic [15:0]       next_tim_word;

    // Timers
    logic [31:0]       scan_cnt;
    logic [31:0]       next_scan_cnt;
    logic [31:0]       fast_cnt;
    logic [31:0]       next_fast_cnt;
    logic [31:0]       slow_cnt;
    logic [31:0]       next_slow_cnt;
    logic              fast_clk;
    logic              next_fast_clk;
    logic              slow_clk;
    logic              next_slow_clk;
    logic              overrun_hit;

    // Interrupt state
    logic [EV_W-1:0]   ev_status;
    logic [EV_W-1:0]   next_ev_status;
    logic [EV_W-1:0]   ev_enable;
    logic [EV_W-1:0]   next_ev_enable;
    logic [EV_W-1:0]   ev_set;
    logic              next_irq;

    logic              wr_ctl;
    logic              wr_err;
    logic              err_clear;

    assign bus_req     = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign bus_wr      = bus_req && wb_we_i;
    assign bus_idx     = wb_adr_i[ADDR_W-1:2];
    assign adr_aligned = (wb_adr_i[1:0] == 2'h0);
    assign wr_ctl      = bus_wr && adr_aligned && bus_idx == IDX_CONTROL && wb_sel_i[0];
    assign wr_err      = bus_wr && adr_aligned && bus_idx == IDX_ERR_STATUS && wb_sel_i[0];
    assign err_clear   = periph_err_clear_i || (wr_ctl && wb_dat_i[CTL_ERR_CLR_BIT]);

    // Timers: scan cycle length and the two free-running pulse clocks
    always_comb begin
        overrun_hit   = 1'b0;
        next_scan_cnt = scan_cnt;
        if (!running || scan_i.scan_end || scan_i.run_start) begin
            next_scan_cnt = 32'h0;
        end else if (scan_cnt < OVERRUN_CYCLES) begin
            next_scan_cnt = scan_cnt + 32'h1;
        end else begin
            overrun_hit = 1'b1;
        end
        next_fast_clk = fast_clk;
        next_fast_cnt = fast_cnt + 32'h1;
        if (fast_cnt >= FAST_HALF - 1) begin
            next_fast_cnt = 32'h0;
            next_fast_clk = !fast_clk;
        end
        next_slow_clk = slow_clk;
        next_slow_cnt = slow_cnt + 32'h1;
        if (slow_cnt >= SLOW_HALF - 1) begin
            next_slow_cnt = 32'h0;
            next_slow_clk = !slow_clk;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            scan_cnt <= 32'h0;
            fast_cnt <= 32'h0;
            slow_cnt <= 32'h0;
            fast_clk <= 1'b1;
            slow_clk <= 1'b1;
        end else if (ce_i) begin
            scan_cnt <= next_scan_cnt;
            fast_cnt <= next_fast_cnt;
            slow_cnt <= next_slow_cnt;
            fast_clk <= next_fast_clk;
            slow_clk <= next_slow_clk;
        end
    end

    // Flags: error code, overrun, first scan, step, monitor, sign, log clear
    always_comb begin
        next_err_code = err_code;
        if (alarm_i.valid) begin
            next_err_code = alarm_i.number;
        end else if (error_i.valid) begin
            next_err_code = error_i.code;
        end else if (err_clear) begin
            next_err_code = RST_CODE;
        end else if (wr_err) begin
            next_err_code = wb_dat_i[ERR_CODE_LSB +: 8];
        end
        // A nonfatal alarm numbered zero loads zero, which is the clear
        next_overrun = overrun;
        if (overrun_hit) begin
            next_overrun = 1'b1;
        end else if (err_clear) begin
            next_overrun = 1'b0;
        end
        next_running = running;
        if (scan_i.run_start) begin
            next_running = 1'b1;
        end else if (scan_i.run_stop) begin
            next_running = 1'b0;
        end
        next_first_scan = first_scan;
        if (scan_i.run_start) begin
            next_first_scan = 1'b1;
        end else if (scan_i.scan_end || scan_i.run_stop) begin
            next_first_scan = 1'b0;
        end
        next_step_flag = step_flag;
        if (scan_i.step_start) begin
            next_step_flag = 1'b1;
        end else if (scan_i.scan_end || scan_i.run_stop) begin
            next_step_flag = 1'b0;
        end
        next_diff_flag = diff_flag;
        if (diff_mon_done_i) begin
            next_diff_flag = 1'b1;
        end else if (diff_mon_start_i) begin
            next_diff_flag = 1'b0;
        end
        next_neg_flag = neg_flag;
        if (arith_valid_i) begin
            next_neg_flag = arith_neg_i;
        end
        next_log_clear = log_clear;
        if (log_clear && log_erase_done_i) begin
            next_log_clear = 1'b0;
        end else if (wr_ctl && wb_dat_i[CTL_LOG_CLR_BIT]) begin
            next_log_clear = 1'b1;
        end
        next_err_word                  = 16'h0000;
        next_err_word[ERR_CODE_LSB+:8] = next_err_code;
        next_err_word[ERR_OVERRUN_BIT] = next_overrun;
        next_err_word[ERR_ONE_BIT]     = 1'b1;
        next_err_word[ERR_ZERO_BIT]    = 1'b0;
        next_err_word[ERR_FIRST_BIT]   = next_first_scan;
        next_tim_word                  = 16'h0000;
        next_tim_word[TIM_SLOW_BIT]    = next_slow_clk;
        next_tim_word[TIM_FAST_BIT]    = next_fast_clk;
        next_tim_word[TIM_NEG_BIT]     = next_neg_flag;
        next_tim_word[TIM_DIFF_BIT]    = next_diff_flag;
        next_tim_word[TIM_STEP_BIT]    = next_step_flag;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            err_code    <= RST_CODE;
            overrun     <= 1'b0;
            running     <= 1'b0;
            first_scan  <= 1'b0;
            step_flag   <= 1'b0;
            diff_flag   <= 1'b0;
            neg_flag    <= 1'b0;
            log_clear   <= 1'b0;
            log_erase_o <= 1'b0;
            err_word_o  <= 16'h2000;
            tim_word_o  <= 16'h0003;
        end else if (ce_i) begin
            err_code    <= next_err_code;
            overrun     <= next_overrun;
            running     <= next_running;
            first_scan  <= next_first_scan;
            step_flag   <= next_step_flag;
            diff_flag   <= next_diff_flag;
            neg_flag    <= next_neg_flag;
            log_clear   <= next_log_clear;
            log_erase_o <= next_log_clear;
            err_word_o  <= next_err_word;
            tim_word_o  <= next_tim_word;
        end
    end

    // Interrupts: sticky status, set wins over a clear in the same cycle
    always_comb begin
        ev_set               = '0;
        ev_set[EV_ERROR]     = error_i.valid;
        ev_set[EV_ALARM]     = alarm_i.valid && (alarm_i.fatal || alarm_i.number != 8'h00);
        ev_set[EV_OVERRUN]   = overrun_hit && !overrun;
        ev_set[EV_DIFF_DONE] = diff_mon_done_i;
        ev_set[EV_STEP]      = scan_i.step_start;
        ev_set[EV_LOG_DONE]  = log_clear && log_erase_done_i;
        next_ev_status       = ev_status;
        next_ev_enable       = ev_enable;
        if (bus_wr && adr_aligned && wb_sel_i[0]) begin
            if (bus_idx == IDX_IRQ_CLEAR) begin
                next_ev_status = ev_status & ~wb_dat_i[EV_W-1:0];
            end
            if (bus_idx == IDX_IRQ_ENABLE) begin
                next_ev_enable = wb_dat_i[EV_W-1:0];
            end
        end
        next_ev_status = next_ev_status | ev_set;
        next_irq       = |(next_ev_status & next_ev_enable);
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ev_status <= RST_EVENTS;
            ev_enable <= RST_EVENTS;
            irq_o     <= 1'b0;
        end else if (ce_i) begin
            ev_status <= next_ev_status;
            ev_enable <= next_ev_enable;
            irq_o     <= next_irq;
        end
    end

    // Bus: one-wait answer, unmapped or misaligned reads give zero
    always_comb begin
        next_ack = bus_req;
        next_dat = 32'h0;
        if (bus_req && !wb_we_i && adr_aligned) begin
            unique case (bus_idx)
                IDX_ERR_STATUS: next_dat = {16'h0, err_word_o};
                IDX_TIMING:     next_dat = {16'h0, tim_word_o};
                IDX_CONTROL:    next_dat = {31'h0, log_clear};
                IDX_IRQ_STATUS: next_dat = {{(32-EV_W){1'b0}}, ev_status};
                IDX_IRQ_ENABLE: next_dat = {{(32-EV_W){1'b0}}, ev_enable};
                default:        next_dat = 32'h0;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0;
        end else if (ce_i) begin
            wb_ack_o <= next_ack;
            wb_dat_o <= next_dat;
        end
    end

endmodule

// *** src/csf_pkg.sv ***
// Constants and carrier types for the controller system flag words
package csf_pkg;

    // Clock rate and time base
    localparam int unsigned CLK_HZ          = 20_000_000;
    localparam int unsigned OVERRUN_MS      = 100;
    localparam int unsigned FAST_HALF_MS    = 10;
    localparam int unsigned SLOW_HALF_S     = 30;
    localparam int unsigned OVERRUN_CYC     = OVERRUN_MS * (CLK_HZ / 1000);
    localparam int unsigned FAST_HALF_CYC   = FAST_HALF_MS * (CLK_HZ / 1000);
    localparam int unsigned SLOW_HALF_CYC   = SLOW_HALF_S * CLK_HZ;

    // Register indices and byte addresses (byte address is four times the index)
    localparam logic [7:0]  IDX_ERR_STATUS  = 8'hfd;
    localparam logic [7:0]  IDX_TIMING      = 8'hfe;
    localparam logic [7:0]  IDX_CONTROL     = 8'hf0;
    localparam logic [7:0]  IDX_IRQ_STATUS  = 8'hf1;
    localparam logic [7:0]  IDX_IRQ_ENABLE  = 8'hf2;
    localparam logic [7:0]  IDX_IRQ_CLEAR   = 8'hf3;
    localparam int          ADDR_W          = 10;

    // Error status word fields
    localparam int          ERR_CODE_LSB    = 0;
    localparam int          ERR_OVERRUN_BIT = 9;
    localparam int          ERR_ONE_BIT     = 13;
    localparam int          ERR_ZERO_BIT    = 14;
    localparam int          ERR_FIRST_BIT   = 15;

    // Timing flags word fields
    localparam int          TIM_SLOW_BIT    = 0;
    localparam int          TIM_FAST_BIT    = 1;
    localparam int          TIM_NEG_BIT     = 2;
    localparam int          TIM_DIFF_BIT    = 6;
    localparam int          TIM_STEP_BIT    = 7;

    // Control register fields
    localparam int          CTL_LOG_CLR_BIT = 0;
    localparam int          CTL_ERR_CLR_BIT = 1;

    // Interrupt event bits
    localparam int          EV_ERROR        = 0;
    localparam int          EV_ALARM        = 1;
    localparam int          EV_OVERRUN      = 2;
    localparam int          EV_DIFF_DONE    = 3;
    localparam int          EV_STEP         = 4;
    localparam int          EV_LOG_DONE     = 5;
    localparam int          EV_W            = 6;

    // Reset values
    localparam logic [7:0]     RST_CODE     = 8'h00;
    localparam logic [EV_W-1:0] RST_EVENTS  = 6'h00;

    // Alarm instruction execution from the scan engine
    typedef struct packed {
        logic       valid;
        logic       fatal;
        logic [7:0] number;
    } csf_alarm_type;

    // Detected error report with its two-digit code
    typedef struct packed {
        logic       valid;
        logic [7:0] code;
    } csf_error_type;

    // Scan engine timing events
    typedef struct packed {
        logic run_start;
        logic run_stop;
        logic scan_end;
        logic step_start;
    } csf_scan_type;

endpackage

// *** verification/csf_flag_words_sva.sv ***
// Port assertions for the system flag words
`timescale 1ns/1ps
module csf_flag_words_sva #(
    parameter int unsigned FAST_HALF = 10
) (
    // Clock, reset, enable
    input wire logic                   clk_i,
    input wire logic                   rst_i,
    input wire logic                   ce_i,
    // Bus handshake
    input wire logic                   wb_cyc_i,
    input wire logic                   wb_stb_i,
    input wire logic                   wb_ack_o,
    // Scan engine events
    input wire csf_pkg::csf_scan_type  scan_i,
    input wire csf_pkg::csf_alarm_type alarm_i,
    input wire csf_pkg::csf_error_type error_i,
    input wire logic                   arith_valid_i,
    input wire logic                   arith_neg_i,
    // Log store
    input wire logic                   log_erase_done_i,
    input wire logic                   log_erase_o,
    // Flag words
    input wire logic [15:0]            err_word_o,
    input wire logic [15:0]            tim_word_o
);
    import csf_pkg::*;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    // Cycles since the fast clock bit last changed; assumes ce_i stays high
    logic        fast_prev;
    logic        fast_seen;
    logic [31:0] fast_cnt;
    logic        fast_tgl;
    assign fast_tgl = tim_word_o[1] != fast_prev;
    always_ff @(posedge clk_i) begin
        fast_prev <= rst_i ? 1'b1 : tim_word_o[1];
        fast_seen <= rst_i ? 1'b0 : fast_seen | fast_tgl;
        fast_cnt  <= (rst_i || fast_tgl) ? 32'h0 : fast_cnt + 32'h1;
    end

    a_ack_once: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o && ce_i |=> wb_ack_o)
        else $error("request not acknowledged next cycle");
    a_fixed_bits: assert property (err_word_o[14:10] == 5'h08 && !err_word_o[8] && tim_word_o[15:8] == 8'h00 && tim_word_o[5:3] == 3'h0)
        else $error("fixed or unused bit wrong");
    a_alarm_load: assert property (alarm_i.valid && ce_i |=> err_word_o[7:0] == $past(alarm_i.number))
        else $error("alarm number not loaded");
    a_error_code: assert property (error_i.valid && !alarm_i.valid && ce_i |=> err_word_o[7:0] == $past(error_i.code))
        else $error("error code not stored");
    a_first_scan: assert property (scan_i.run_start && ce_i |=> err_word_o[15])
        else $error("first scan flag not set");
    a_step_flag: assert property (scan_i.step_start && ce_i |=> tim_word_o[7])
        else $error("step flag not set");
    a_neg_flag: assert property (arith_valid_i && ce_i |=> tim_word_o[2] == $past(arith_neg_i))
        else $error("negative flag wrong");
    a_fast_period: assert property (fast_tgl && fast_seen |-> fast_cnt == FAST_HALF - 1)
        else $error("fast clock half period wrong");
    a_log_held: assert property (log_erase_o && !log_erase_done_i && ce_i |=> log_erase_o)
        else $error("log erase dropped early");
endmodule

bind csf_flag_words csf_flag_words_sva #(.FAST_HALF(FAST_HALF)) u_sva (
    .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
    .scan_i(scan_i), .alarm_i(alarm_i), .error_i(error_i), .arith_valid_i(arith_valid_i),
    .arith_neg_i(arith_neg_i), .log_erase_done_i(log_erase_done_i), .log_erase_o(log_erase_o),
    .err_word_o(err_word_o), .tim_word_o(tim_word_o)
);

// *** verification/csf_tool_model.sv ***
// Error log store and differential monitor answering the flag words
`timescale 1ns/1ps
module csf_tool_model #(
    parameter int unsigned DELAY = 8
) (
    // Clock
    input  wire logic clk_i,
    // Requests
    input  wire logic log_erase_i,
    input  wire logic diff_start_i,
    // Completions
    output logic      log_done_o,
    output logic      diff_done_o
);
    int unsigned log_cnt = 0;
    int unsigned diff_cnt = 0;
    initial begin
        log_done_o = 1'b0;
        diff_done_o = 1'b0;
    end
    // One completion pulse per request, DELAY cycles after it
    always @(posedge clk_i) begin
        log_done_o <= log_cnt == DELAY;
        log_cnt <= (log_erase_i && log_cnt <= DELAY) ? log_cnt + 1 : 0;
        diff_done_o <= diff_cnt == DELAY;
        diff_cnt <= diff_start_i ? 1 : ((diff_cnt != 0 && diff_cnt <= DELAY) ? diff_cnt + 1 : 0);
    end
endmodule

// *** verification/controller_system_flag_words_bench.sv ***
// Self-checking bench for the system flag words
`timescale 1ns/1ps
module controller_system_flag_words_bench;
    import csf_pkg::*;
    localparam int unsigned OVR = 50;
    localparam int unsigned FH  = 10;
    localparam int unsigned SH  = 30;
    logic          clk_i = 1'b0;
    logic          rst_i = 1'b1;
    logic          cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic [9:0]    adr = '0;
    logic [31:0]   wdat = '0, rdat, q;
    logic          ack, log_erase, log_done, diff_done, irq;
    logic          arith_v = 1'b0, neg = 1'b0, pclr = 1'b0, dstart = 1'b0;
    logic [15:0]   err, tim;
    csf_scan_type  scan = '0;
    csf_alarm_type alarm = '0;
    csf_error_type error = '0;
    int            miscompares = 0, checked = 0, n;

    always #25 clk_i = ~clk_i;

    csf_flag_words #(.OVERRUN_CYCLES(OVR), .FAST_HALF(FH), .SLOW_HALF(SH)) DUT (
        .clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .scan_i(scan), .alarm_i(alarm), .error_i(error), .arith_valid_i(arith_v), .arith_neg_i(neg),
        .periph_err_clear_i(pclr), .diff_mon_start_i(dstart), .diff_mon_done_i(diff_done),
        .log_erase_done_i(log_done), .log_erase_o(log_erase), .err_word_o(err), .tim_word_o(tim), .irq_o(irq));
    csf_tool_model #(.DELAY(8)) tool (.clk_i(clk_i), .log_erase_i(log_erase), .diff_start_i(dstart),
        .log_done_o(log_done), .diff_done_o(diff_done));

    task automatic summarize;
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected at %0t: %s", $time, m);
        end
    endtask
    // Classic single Wishbone cycle, held until ack is sampled
    task automatic wb(input logic w, input logic [7:0] idx, input logic [31:0] d, output logic [31:0] r);
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= {idx, 2'h0};
        wdat <= d;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1 && n < 20);
        r = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        if (n >= 20) begin
            chk(0, 1, "no ack");
            summarize();
        end
    endtask
    // One-cycle event pulse, then one cycle for the words to settle
    task automatic fire(input csf_scan_type s, input csf_alarm_type a, input csf_error_type e, input logic [3:0] m);
        @(posedge clk_i);
        scan <= s;
        alarm <= a;
        error <= e;
        {arith_v, pclr, dstart, neg} <= m;
        @(posedge clk_i);
        scan <= '0;
        alarm <= '0;
        error <= '0;
        {arith_v, pclr, dstart} <= 3'h0;
        @(posedge clk_i);
    endtask
    task automatic half(input int b, input int exp);
        logic v;
        repeat (2) begin
            v = tim[b];
            n = 0;
            while (tim[b] === v && n < 4 * exp) begin
                @(posedge clk_i);
                n++;
            end
        end
        chk(n, exp, "pulse clock half period");
    endtask

    task automatic t_regs;
        chk(err, 16'h2000, "err word reset");
        chk(tim, 16'h0003, "timing word reset");
        wb(1'b1, IDX_ERR_STATUS, 32'hffff_ffff, q);
        wb(1'b0, IDX_ERR_STATUS, 32'h0, q);
        chk(q, 32'h0000_20ff, "err word write mask");
        wb(1'b1, IDX_TIMING, 32'hffff_ffff, q);
        wb(1'b0, IDX_TIMING, 32'h0, q);
        chk(q & 32'hffff_fffc, 32'h0, "timing word read only");
        wb(1'b0, 8'h40, 32'h0, q);
        chk(q, 32'h0, "unmapped read");
        $display("test regs done");
    endtask
    task automatic t_code;
        fire('0, '0, '{1'b1, 8'h42}, 4'h0);
        chk(err[7:0], 8'h42, "error code");
        fire('0, '{1'b1, 1'b0, 8'h12}, '{1'b1, 8'h55}, 4'h0);
        chk(err[7:0], 8'h12, "nonfatal alarm number");
        fire('0, '{1'b1, 1'b1, 8'h34}, '0, 4'h0);
        chk(err[7:0], 8'h34, "fatal alarm number");
        fire('0, '{1'b1, 1'b0, 8'h00}, '0, 4'h0);
        chk(err[7:0], 8'h00, "alarm zero clears");
        fire('0, '0, '{1'b1, 8'h07}, 4'h0);
        fire('0, '0, '0, 4'h4);
        chk(err[7:0], 8'h00, "tool clear");
        fire('0, '0, '{1'b1, 8'h03}, 4'h0);
        wb(1'b1, IDX_CONTROL, 32'h2, q);
        chk(err[7:0], 8'h00, "control clear");
        $display("test code done");
    endtask
    task automatic t_scan;
        fire(4'h8, '0, '0, 4'h0);
        chk(err[15], 1'b1, "first scan set");
        fire(4'h2, '0, '0, 4'h0);
        chk(err[15], 1'b0, "first scan ends");
        fire(4'h1, '0, '0, 4'h0);
        chk(tim[7], 1'b1, "step flag set");
        fire(4'h2, '0, '0, 4'h0);
        chk(tim[7], 1'b0, "step flag ends");
        repeat (3) begin
            repeat (OVR - 10) @(posedge clk_i);
            fire(4'h2, '0, '0, 4'h0);
        end
        chk(err[9], 1'b0, "no overrun");
        repeat (OVR + 5) @(posedge clk_i);
        chk(err[9], 1'b1, "overrun set");
        fire(4'h4, '0, '0, 4'h4);
        fire('0, '0, '0, 4'h4);
        chk(err[9], 1'b0, "overrun cleared");
        $display("test scan done");
    endtask
    task automatic t_flags;
        fire('0, '0, '0, 4'h9);
        chk(tim[2], 1'b1, "negative result");
        fire('0, '0, '0, 4'h8);
        chk(tim[2], 1'b0, "positive result");
        repeat (2) begin
            fire('0, '0, '0, 4'h2);
            chk(tim[6], 1'b0, "monitor start clears");
            for (int i = 0; i < 40 && tim[6] !== 1'b1; i++) @(posedge clk_i);
            chk(tim[6], 1'b1, "monitor done");
        end
        half(1, FH);
        half(0, SH);
        $display("test flags done");
    endtask
    task automatic t_log;
        wb(1'b1, IDX_CONTROL, 32'h1, q);
        chk(log_erase, 1'b1, "erase requested");
        wb(1'b0, IDX_CONTROL, 32'h0, q);
        chk(q, 32'h1, "erase bit reads one");
        for (int i = 0; i < 40 && log_erase !== 1'b0; i++) @(posedge clk_i);
        wb(1'b0, IDX_CONTROL, 32'h0, q);
        chk(q, 32'h0, "erase bit self clears");
        $display("test log done");
    endtask
    task automatic t_irq;
        wb(1'b1, IDX_IRQ_CLEAR, 32'h3f, q);
        wb(1'b1, IDX_IRQ_ENABLE, 32'h1, q);
        chk(irq, 1'b0, "irq idle");
        fire('0, '0, '{1'b1, 8'h01}, 4'h0);
        chk(irq, 1'b1, "irq raised");
        wb(1'b1, IDX_IRQ_CLEAR, 32'h1, q);
        chk(irq, 1'b0, "irq cleared");
        wb(1'b1, IDX_IRQ_ENABLE, 32'h0, q);
        fire('0, '0, '{1'b1, 8'h02}, 4'h0);
        chk(irq, 1'b0, "irq masked");
        wb(1'b0, IDX_IRQ_STATUS, 32'h0, q);
        chk(q[0], 1'b1, "status sticky");
        wb(1'b0, IDX_IRQ_CLEAR, 32'h0, q);
        chk(q, 32'h0, "clear reads zero");
        $display("test irq done");
    endtask

    initial begin
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        t_regs();
        t_code();
        t_scan();
        t_flags();
        t_log();
        t_irq();
        summarize();
    end
endmodule
